// ---- rtl/rmd_params.svh ----
// Purpose: Constants of the median deglitch filter
// Assumes: Included by the package and design files
// Notes: Definitions only
`ifndef RMD_PARAMS_SVH
`define RMD_PARAMS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define RMD_HIST_W 15
`define RMD_CNT_W 4
`define RMD_CFG_W 4
`define RMD_WORD_W 6

// ----------------------------------------
// Window limits and oversampling figures
// ----------------------------------------
`define RMD_WIN_MIN 4'h1
`define RMD_WIN_MAX 4'hF
`define RMD_OVS_MIN 5
`define RMD_OVS_MAX 10
`define RMD_SPIKE_MAX 4'h2
`define RMD_SPIKE_WIN 4'h5

// ----------------------------------------
// Buffering
// ----------------------------------------
`define RMD_FIFO_DEPTH 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RMD_HIST_RST 15'h0000
`define RMD_CNT_RST 4'h0
`define RMD_CFG_RST 4'h0
`define RMD_WIN_RST 4'h1

`endif

// ---- rtl/rmd_pkg.sv ----
// Purpose: Types of the median deglitch filter
// Assumes: rmd_params.svh gives the widths
// Notes: No logic here
`include "rmd_params.svh"

package rmd_pkg;

	typedef logic [`RMD_HIST_W-1:0] rmd_hist_t;
	typedef logic [`RMD_CNT_W-1:0] rmd_count_t;
	typedef logic [`RMD_CFG_W-1:0] rmd_cfg_t;

	// Capture of straps, then free running filter
	typedef enum logic {
		RMD_ST_CAPTURE,
		RMD_ST_RUN
	} rmd_state_e;

	// One filtered sample as it leaves through the buffer
	typedef struct packed {
		logic filtered;
		logic raw;
		rmd_count_t ones_count;
	} rmd_word_s;

endpackage

// ---- rtl/rmd_fifo.sv ----
// Purpose: Small flip-flop FIFO with valid/ready on both sides
// Assumes: One clock, synchronous active-low reset
// Notes: Full and empty are exact; no write while full
`timescale 1ns/1ps
`default_nettype none

module rmd_fifo #(
	parameter int WIDTH = 6,
	parameter int DEPTH = 4
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0] wr_idx;
	logic [AW-1:0] rd_idx;
	logic [AW:0] fill;
	logic do_wr;
	logic do_rd;

	// ----------------------------------------
	// Handshake decode
	// ----------------------------------------
	// Compared at the counter's width: DEPTH itself does not fit in AW bits
	assign in_ready_out = (fill != (AW+1)'(DEPTH));
	assign out_valid_out = (fill != '0);
	assign do_wr = in_valid_in & in_ready_out;
	assign do_rd = out_valid_out & out_ready_in;
	assign out_data_out = store[rd_idx];

	// Pointers wrap at DEPTH so any depth works
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			wr_idx <= '0;
			rd_idx <= '0;
			fill <= '0;
		end
		else
		begin
			if (do_wr)
				wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
			if (do_rd)
				rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
			fill <= fill + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end

	// Storage needs no reset; valid gates every read
	always_ff @(posedge clk_in)
	begin
		if (do_wr)
			store[wr_idx] <= in_data_in;
	end

endmodule // rmd_fifo

`default_nettype wire

// ---- rtl/rmd_deglitch.sv ----
// Purpose: Majority (median) deglitch filter on the demodulated data pin
// Assumes: clk_in 100 MHz; sample_tick_in one pulse per oversampling tick
// Notes: Window length and packet switches are caught once after reset
//
// Notes on behaviour
// - Take the raw data pin once per tick; tick is 5-10x data rate.
// - Window length is one to fifteen samples, fixed before running.
// - Ones count and history update on every oversampling tick taken while the buffer has room.
// - Oldest-position mask is one-hot at bit window length minus one.
// - Decrement the count when the oldest bit is one, before shifting.
// - Shift history left, new sample into bit zero, count it if one.
// - Output is one when count exceeds window length divided by two.
// - Spikes of one or two ticks are removed from the data when the window is five or more.
// - Filtering and retiming step are evaluated in the same tick.
// - Packet-type switches caught once at start; later changes ignored.
`timescale 1ns/1ps
`default_nettype none
`include "rmd_params.svh"

module rmd_deglitch (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic demod_data_in,
	input wire logic sample_tick_in,
	input wire logic [3:0] window_len_in,
	input wire logic [3:0] packet_switch_in,
	output logic sample_ready_out,
	output logic filtered_sample_out,
	output logic [3:0] ones_count_out,
	output logic [3:0] window_len_out,
	output logic [3:0] packet_type_out,
	output logic config_valid_out,
	output logic overrun_out,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output rmd_pkg::rmd_word_s out_data_out
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	rmd_pkg::rmd_state_e state;
	rmd_pkg::rmd_state_e next_state;
	rmd_pkg::rmd_hist_t sample_history;
	rmd_pkg::rmd_hist_t next_history;
	rmd_pkg::rmd_hist_t oldest_position_mask;
	rmd_pkg::rmd_hist_t window_bits;
	rmd_pkg::rmd_count_t ones_count;
	rmd_pkg::rmd_count_t next_count;
	rmd_pkg::rmd_count_t window_len;
	rmd_pkg::rmd_count_t majority_threshold;
	rmd_pkg::rmd_cfg_t packet_type;
	rmd_pkg::rmd_word_s push_word;
	logic filtered_sample;
	logic next_filtered;
	logic overrun;
	logic running;
	logic oldest_bit;
	logic tick_take;
	logic tick_lost;
	logic fifo_ready;
	logic [4:0] count_wide;
	logic [3:0] len_clamped;

	// ----------------------------------------
	// Window decode
	// ----------------------------------------

	// A zero strap would give an empty window, so it counts as one
	assign len_clamped = (window_len_in == 4'h0) ? `RMD_WIN_MIN
		: window_len_in;

	// One-hot mask on the sample about to leave the window
	assign oldest_position_mask =
		rmd_pkg::rmd_hist_t'(15'h0001 << (window_len - 4'h1));
	assign window_bits = rmd_pkg::rmd_hist_t'(
		{oldest_position_mask, 1'b0} - 16'h0001);
	assign oldest_bit = |(sample_history & oldest_position_mask);

	// Halving truncates, so odd windows need a strict majority
	assign majority_threshold = window_len >> 1;

	// ----------------------------------------
	// Tick acceptance
	// ----------------------------------------

	// A tick is taken only while the buffer has room; a full buffer
	// would otherwise lose a filtered sample without trace
	assign running = (state == rmd_pkg::RMD_ST_RUN);
	assign tick_take = running & sample_tick_in & fifo_ready;
	assign tick_lost = running & sample_tick_in & ~fifo_ready;
	assign sample_ready_out = running & fifo_ready;

	// ----------------------------------------
	// Next history, count and output
	// ----------------------------------------

	// Leaving sample out first, new sample in second
	assign count_wide = {1'b0, ones_count} - {4'h0, oldest_bit}
		+ {4'h0, demod_data_in};
	assign next_history = tick_take
		? {sample_history[`RMD_HIST_W-2:0], demod_data_in}
		: sample_history;
	assign next_count = tick_take ? count_wide[3:0] : ones_count;

	// Decided from the new count so the filtered value is ready at the
	// same edge the sample is taken, leaving a retimer the same tick
	assign next_filtered = (next_count > majority_threshold);

	// ----------------------------------------
	// Start-up sequencing
	// ----------------------------------------

	// The receiver sets itself up from its own straps and needs no
	// command, so the filter only waits for its own capture
	always_comb
	begin
		next_state = state;
		case (state)
			rmd_pkg::RMD_ST_CAPTURE: next_state = rmd_pkg::RMD_ST_RUN;
			rmd_pkg::RMD_ST_RUN: next_state = rmd_pkg::RMD_ST_RUN;
			default: next_state = rmd_pkg::RMD_ST_CAPTURE;
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
			state <= rmd_pkg::RMD_ST_CAPTURE;
		else
			state <= next_state;
	end

	// Straps caught once at the edge after reset release
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			window_len <= `RMD_WIN_RST;
			packet_type <= `RMD_CFG_RST;
		end
		else if (state == rmd_pkg::RMD_ST_CAPTURE)
		begin
			window_len <= len_clamped;
			packet_type <= packet_switch_in;
		end
	end

	// ----------------------------------------
	// Filter registers
	// ----------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			sample_history <= `RMD_HIST_RST;
			ones_count <= `RMD_CNT_RST;
			filtered_sample <= 1'b0;
		end
		else
		begin
			sample_history <= next_history;
			ones_count <= next_count;
			filtered_sample <= next_filtered;
		end
	end

	// Lost tick is sticky until reset; no software clears it
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
			overrun <= 1'b0;
		else if (tick_lost)
			overrun <= 1'b1;
	end

	// ----------------------------------------
	// Output buffer
	// ----------------------------------------

	// Word pushed carries the value the registers take at this edge
	assign push_word.filtered = next_filtered;
	assign push_word.raw = demod_data_in;
	assign push_word.ones_count = next_count;

	rmd_fifo #(
		.WIDTH(`RMD_WORD_W),
		.DEPTH(`RMD_FIFO_DEPTH)
	) u_fifo (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.in_valid_in(tick_take),
		.in_ready_out(fifo_ready),
		.in_data_in(push_word),
		.out_valid_out(out_valid_out),
		.out_ready_in(out_ready_in),
		.out_data_out(out_data_out)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign filtered_sample_out = filtered_sample;
	assign ones_count_out = ones_count;
	assign window_len_out = window_len;
	assign packet_type_out = packet_type;
	assign config_valid_out = running;
	assign overrun_out = overrun;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------

	// Count always equals the ones inside the window
	AST_COUNT_MATCH: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		running |-> (32'(ones_count)
			== $countones(sample_history & window_bits)))
		else $error("ones count differs from window contents");

	// Mask is one-hot at window length minus one
	AST_MASK_ONEHOT: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		running |-> ($onehot(oldest_position_mask)
			&& oldest_position_mask[window_len - 4'h1]))
		else $error("oldest position mask misplaced");

	// Taken tick shifts left with the raw sample in bit zero
	AST_SHIFT_IN: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		tick_take |=> (sample_history[0] == $past(demod_data_in))
			&& (sample_history[14:1] == $past(sample_history[13:0])))
		else $error("history did not shift in the sample");

	// Count moves by new sample minus the leaving one
	AST_COUNT_STEP: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		tick_take |=> (5'(ones_count) + 5'($past(oldest_bit))
			== 5'($past(ones_count)) + 5'($past(demod_data_in))))
		else $error("ones count step wrong");

	// Without a tick nothing in the window moves
	AST_HOLD: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		!tick_take |=> $stable(sample_history) && $stable(ones_count))
		else $error("window moved without a tick");

	// Output follows strict majority of the current count
	AST_MAJORITY: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		running |-> (filtered_sample == (ones_count > majority_threshold)))
		else $error("filtered output not the majority");

	// Two or fewer ones never pass a window of five or more
	AST_SPIKE: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		(running && window_len >= `RMD_SPIKE_WIN
			&& ones_count <= `RMD_SPIKE_MAX) |-> !filtered_sample)
		else $error("short spike reached the output");

	// Straps stay frozen once running, window length in range
	AST_CFG_FROZEN: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		running |=> $stable(packet_type) && $stable(window_len)
			&& (window_len >= `RMD_WIN_MIN))
		else $error("captured setup changed while running");

	// Capture cycle after reset starts from a clean window
	AST_RESET_CLEAR: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		(state == rmd_pkg::RMD_ST_CAPTURE) |-> (sample_history == '0)
			&& (ones_count == '0) && !filtered_sample)
		else $error("state not cleared after reset");

	// Pushed word matches the filtered value of the same edge
	AST_SAME_TICK: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		tick_take |=> (filtered_sample == $past(next_filtered)))
		else $error("filtered sample not taken with the tick");

	// Captured length is the strap, with zero taken as one
	AST_WIN_CAPTURE: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		(state == rmd_pkg::RMD_ST_CAPTURE) |=> (window_len
			== (($past(window_len_in) == 4'h0) ? `RMD_WIN_MIN
			: $past(window_len_in))))
		else $error("window length not captured from the strap");

	// A refused tick leaves the window alone and marks the loss
	AST_TICK_LOST: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		tick_lost |=> overrun && $stable(sample_history)
			&& $stable(ones_count))
		else $error("lost tick not flagged or window moved");

	// Every taken tick leaves a word waiting in the buffer
	AST_TICK_PUSH: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		tick_take |=> out_valid_out)
		else $error("taken tick left no word in the buffer");

endmodule // rmd_deglitch

`default_nettype wire

// ---- verif/rmd_rx_model.sv ----
// Purpose: Receiver model driving the demodulated data pin
// Assumes: PER clocks per data bit; bit_in taken at each bit start
// Notes: A glitch flips the pin mid-bit for glitch_len_in clocks
`timescale 1ns/1ps
`default_nettype none

module rmd_rx_model #(
	parameter int PER = 8
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic bit_in,
	input wire logic [1:0] glitch_len_in,
	output logic demod_data_out
);
	int phase;
	logic cur;
	logic hit;

	// Glitch sits mid-bit so it never merges with a real edge
	assign hit = phase >= PER / 2 && phase < PER / 2 + int'(glitch_len_in);

	// ----------------------------------------
	// Bit timing
	// ----------------------------------------
	// Runs on its own once out of reset, no host control
	always @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			phase <= 0;
			cur <= 1'h0;
			demod_data_out <= 1'h0;
		end
		else
		begin
			phase <= (phase == PER - 1) ? 0 : phase + 1;
			if (phase == PER - 1)
				cur <= bit_in;
			demod_data_out <= cur ^ hit;
		end
	end
endmodule // rmd_rx_model

`default_nettype wire

// ---- verif/test_rmd_deglitch.sv ----
// Purpose: Self-checking bench of the deglitch filter
// Assumes: Ticks every cycle or random; receiver model drives data
// Notes: Expected words queued by the driver side, checked on output
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
	$display("mismatch %s expected %0h seen %0h", n, e, g); end end

module test_rmd_deglitch;
	logic clk_in = 1'h0;
	logic reset_n_in = 1'h0;
	logic tick = 1'h0;
	logic out_ready = 1'h1;
	logic bit_v = 1'h0;
	logic [1:0] glen = 2'h0;
	logic [3:0] win = 4'h1;
	logic [3:0] sw = 4'h0;
	logic demod, s_rdy, filt, cfg_ok, ovr, o_valid;
	logic [3:0] cnt, wl, pt;
	rmd_pkg::rmd_word_s o_data, w;
	logic [14:0] mh = 15'h0;
	logic [3:0] mc = 4'h0;
	logic [3:0] mlen = 4'h1;
	logic mf = 1'h0;
	logic [3:0] lens [5] = '{4'h1, 4'h2, 4'h5, 4'hF, 4'h0};
	rmd_pkg::rmd_word_s q[$];
	int fails = 0;
	int compares = 0;
	int seed = 32'h540b;
	int i;

	always #5 clk_in = ~clk_in;

	rmd_rx_model u_rmd_rx_model (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.bit_in(bit_v), .glitch_len_in(glen), .demod_data_out(demod));

	rmd_deglitch u_rmd_deglitch (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.demod_data_in(demod), .sample_tick_in(tick), .window_len_in(win),
		.packet_switch_in(sw), .sample_ready_out(s_rdy),
		.filtered_sample_out(filt), .ones_count_out(cnt),
		.window_len_out(wl), .packet_type_out(pt), .config_valid_out(cfg_ok),
		.overrun_out(ovr), .out_valid_out(o_valid), .out_ready_in(out_ready),
		.out_data_out(o_data));

	// ----------------------------------------
	// Reference window, updated on each taken tick
	// ----------------------------------------
	always @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			mh = 15'h0;
			mc = 4'h0;
			mf = 1'h0;
			q.delete();
		end
		else if (tick && s_rdy)
		begin
			if (mh[mlen - 4'h1])
				mc = mc - 4'h1;
			mh = {mh[13:0], demod};
			mc = mc + {3'h0, demod};
			mf = mc > (mlen >> 1);
			q.push_back({mf, demod, mc});
		end
	end

	// Oldest note against each word leaving the buffer
	always @(posedge clk_in)
	begin
		if (reset_n_in && o_valid && out_ready)
		begin
			if (q.size() == 0)
				w = 'x;
			else
				w = q.pop_front();
			`CHK("word", w, o_data)
		end
	end

	// Mid-cycle, so both the design and the reference have settled
	always @(negedge clk_in)
	begin
		`CHK("count", mc, cnt)
		`CHK("filtered", mf, filt)
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic cycles(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	task automatic do_reset(input logic [3:0] len, input logic [3:0] s);
		@(posedge clk_in);
		reset_n_in <= 1'h0;
		tick <= 1'h0;
		win <= len;
		sw <= s;
		cycles(4);
		mlen = (len == 4'h0) ? 4'h1 : len;
		reset_n_in <= 1'h1;
		cycles(2);
		#1;
		`CHK("window", mlen, wl)
		`CHK("switches", s, pt)
		`CHK("config valid", 1'h1, cfg_ok)
		`CHK("overrun", 1'h0, ovr)
		@(posedge clk_in);
		win <= ~len;
		sw <= ~s;
	endtask

	task automatic test_done;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		// Window lengths at both ends, zero clamps to one
		foreach (lens[k])
		begin
			do_reset(lens[k], lens[k] ^ 4'hA);
			tick <= 1'h1;
			for (i = 0; i < 80; i++)
			begin
				@(posedge clk_in);
				bit_v <= 1'($random(seed));
				glen <= {1'h0, 1'($random(seed))} + 2'h1;
			end
			`CHK("window held", mlen, wl)
			`CHK("switches held", lens[k] ^ 4'hA, pt)
			$display("test window %0d done", mlen);
		end
		// Two-tick spikes on a steady one, then a steady zero, must vanish
		do_reset(4'h5, 4'h3);
		glen <= 2'h2;
		tick <= 1'h1;
		for (int b = 1; b >= 0; b--)
		begin
			@(posedge clk_in);
			bit_v <= 1'(b);
			cycles(24);
			for (i = 0; i < 40; i++)
			begin
				@(negedge clk_in);
				`CHK("deglitched", 1'(b), filt)
			end
		end
		$display("test glitch done");
		// Fill the buffer until ticks are refused, then drain it
		do_reset(4'h3, 4'h0);
		out_ready <= 1'h0;
		tick <= 1'h1;
		cycles(8);
		#1;
		`CHK("words held", 4, q.size())
		`CHK("sample ready", 1'h0, s_rdy)
		`CHK("overrun", 1'h1, ovr)
		@(posedge clk_in);
		tick <= 1'h0;
		out_ready <= 1'h1;
		for (i = 0; i < 10 && o_valid !== 1'h0; i++)
			@(posedge clk_in);
		#1;
		`CHK("drained", 1'h0, o_valid)
		`CHK("notes left", 0, q.size())
		$display("test buffer done");
		// Random ticks, data and consumer stalls
		do_reset(4'h7, 4'h5);
		for (i = 0; i < 400; i++)
		begin
			@(posedge clk_in);
			tick <= 1'($random(seed));
			out_ready <= 1'($random(seed));
			bit_v <= 1'($random(seed));
		end
		@(posedge clk_in);
		tick <= 1'h0;
		out_ready <= 1'h1;
		cycles(8);
		`CHK("random left", 0, q.size())
		$display("test random done");
		test_done;
	end

	// Whole run needs about 1000 cycles
	initial
	begin
		repeat (5000) @(posedge clk_in);
		fails++;
		test_done;
	end
endmodule // test_rmd_deglitch

`undef CHK
`default_nettype wire
